// ### hdl/analog_bus_defs.svh
`ifndef ANALOG_BUS_DEFS_SVH
`define ANALOG_BUS_DEFS_SVH

// ****************************************
// Register offsets
// ****************************************
`define REG_CTRL        4'h0
`define REG_STATUS_OUT  4'h1
`define REG_SWITCH      4'h2
`define REG_CONV        4'h3
`define REG_RESULT      4'h4
`define REG_STATE       4'h5
`define REG_SERIAL      4'h6

// ****************************************
// Field positions and reset values
// ****************************************
`define CTRL_DAC_CLR    0
`define CTRL_DRV_EN     1
`define CTRL_SPARE      2
`define CTRL_RESET      3'h0
`define STATUS_RESET    4'h0
`define SS_SWITCH_MSB   11
`define SS_BOARD_LSB    12
`define STATE_SEQ_BUSY  0
`define STATE_RES_VALID 1
`define STATE_SER_BUSY  2
`define SER_BITS        24

// ****************************************
// Timing
// ****************************************
`define CLK_MHZ         200
`define CYC_UP(ns)      ((((ns) * `CLK_MHZ) + 999) / 1000)
`define SETUP_NS        5
`define STROBE_NS       20
`define AD_SETTLE_NS    100
`define SER_HALF_NS     50
`define BUS_CLK_HALF_NS 10
`define SETUP_CYC       `CYC_UP(`SETUP_NS)
`define STROBE_CYC      `CYC_UP(`STROBE_NS)
`define AD_SETTLE_CYC   `CYC_UP(`AD_SETTLE_NS)
`define SER_HALF_CYC    `CYC_UP(`SER_HALF_NS)
`define BUS_CLK_HALF_CYC `CYC_UP(`BUS_CLK_HALF_NS)

`endif

// ### hdl/analog_bus_pkg.sv
package analog_bus_pkg;

  typedef enum logic [2:0] {
    SEQ_IDLE,
    SEQ_SW_SETUP,
    SEQ_SW_STROBE,
    SEQ_AD_SETUP,
    SEQ_AD_STROBE,
    SEQ_AD_WAIT
  } seq_state_t;

  typedef struct packed {
    seq_state_t  st;
    logic [7:0]  cnt;
    logic [15:0] ss;
    logic [4:0]  sel;
    logic        wrss;
    logic        adstr;
    logic [17:0] result;
    logic        res_valid;
    logic [2:0]  ctrl;
    logic [3:0]  status;
    logic [7:0]  bdiv;
    logic        bclk;
    logic [23:0] ser_word;
    logic        ser_load;
    logic [31:0] rdata;
  } bus_state_t;

  typedef struct packed {
    logic        busy;
    logic        sck;
    logic [23:0] sh;
    logic [4:0]  bits;
    logic [7:0]  div;
  } ser_state_t;

endpackage

// ### hdl/analog_serial_tx.sv
`timescale 1ns/1ps
`include "analog_bus_defs.svh"

module analog_serial_tx (
  input  wire logic        mclk,
  input  wire logic        rst_sync_b,
  input  wire logic        load,
  input  wire logic [23:0] word,
  output logic             busy,
  output logic             sck,
  output logic             sdo
);

  analog_bus_pkg::ser_state_t s_q;
  analog_bus_pkg::ser_state_t s_d;

  // ****************************************
  // Shifter, MSB first, data moves on the falling clock
  // ****************************************
  always_comb begin
    s_d = s_q;
    if (!s_q.busy) begin
      if (load) begin
        s_d.busy = 1'b1;
        s_d.sh   = word;
        s_d.bits = 5'h00;
        s_d.div  = 8'h00;
        s_d.sck  = 1'b0;
      end
    end else if (s_q.div == 8'(`SER_HALF_CYC - 1)) begin
      s_d.div = 8'h00;
      if (!s_q.sck) begin
        s_d.sck = 1'b1;
      end else begin
        s_d.sck = 1'b0;
        s_d.sh  = {s_q.sh[22:0], 1'b0};
        if (s_q.bits == 5'(`SER_BITS - 1)) begin
          s_d.busy = 1'b0;
        end else begin
          s_d.bits = s_q.bits + 5'h01;
        end
      end
    end else begin
      s_d.div = s_q.div + 8'h01;
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign busy = s_q.busy;
  assign sck  = s_q.sck;
  assign sdo  = s_q.sh[23];

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_sync_b);

  ser_data_stable_a: assert property (sck && $past(sck) |-> $stable(sdo))
    else $error("serial data moved while serial clock high");
  ser_idle_low_a: assert property (!busy |-> !sck)
    else $error("serial clock high while idle");

endmodule

// ### hdl/timing_board_analog_bus.sv
// How it works
// - Bus bits 0-11 switches, 12-15 board select
// - Write strobe rises only on a valid bus
// - Five-bit select picks one of 32 converters
// - Read strobe pulse makes video board drive result
// - Result line 0 is the least significant bit
// - Asserted clear empties every analog board DAC
// - Enable on turns drivers and biases on
// - Device generates and drives the system clock
// - Device drives serial clock and data itself
// - Four status outputs, each set by software
// - Spare output holds level until rewritten
// - Enable, strobes, data, select, switches active high
// - DAC clear is active low
//
// Added by the designer: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "analog_bus_defs.svh"

module timing_board_analog_bus (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  output logic      [15:0] switch_state_bus,
  output logic             switch_write_strobe,
  output logic      [4:0]  converter_select,
  output logic             converter_read_strobe,
  input  wire logic [17:0] converter_result_lines,
  output logic             dac_clear_all_b,
  output logic             driver_output_enable,
  output logic             system_bus_clock,
  output logic             analog_serial_clock,
  output logic             analog_serial_data,
  output logic      [3:0]  general_status_outputs,
  output logic             spare_latched_output
);

  // ****************************************
  // Reset release
  // ****************************************
  logic rst_meta_q;
  logic rst_sync_b;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_q <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_b <= rst_meta_q;
    end
  end

  // ****************************************
  // State
  // ****************************************
  analog_bus_pkg::bus_state_t s_q;
  analog_bus_pkg::bus_state_t s_d;
  logic                       ser_busy;

  function automatic logic hit(input logic [3:0] addr, input logic [3:0] offs);
    hit = (addr == offs);
  endfunction

  logic wr_ctrl;
  logic wr_status;
  logic wr_switch;
  logic wr_conv;
  logic wr_serial;
  logic seq_idle;

  assign wr_ctrl   = reg_wr && hit(reg_addr, `REG_CTRL);
  assign wr_status = reg_wr && hit(reg_addr, `REG_STATUS_OUT);
  assign wr_switch = reg_wr && hit(reg_addr, `REG_SWITCH);
  assign wr_conv   = reg_wr && hit(reg_addr, `REG_CONV);
  assign wr_serial = reg_wr && hit(reg_addr, `REG_SERIAL);
  assign seq_idle  = (s_q.st == analog_bus_pkg::SEQ_IDLE);

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_d          = s_q;
    s_d.ser_load = 1'b0;

    if (wr_ctrl) begin
      s_d.ctrl = reg_wdata[2:0];
    end
    if (wr_status) begin
      s_d.status = reg_wdata[3:0];
    end
    if (wr_serial && !ser_busy && !s_q.ser_load) begin
      s_d.ser_word = reg_wdata[23:0];
      s_d.ser_load = 1'b1;
    end

    // Reading the result consumes it; a sample in the same cycle wins
    if (reg_rd && hit(reg_addr, `REG_RESULT)) begin
      s_d.res_valid = 1'b0;
    end

    // System clock divider
    if (s_q.bdiv == 8'(`BUS_CLK_HALF_CYC - 1)) begin
      s_d.bdiv = 8'h00;
      s_d.bclk = !s_q.bclk;
    end else begin
      s_d.bdiv = s_q.bdiv + 8'h01;
    end

    case (s_q.st)
      analog_bus_pkg::SEQ_IDLE: begin
        s_d.cnt = 8'h00;
        if (wr_switch) begin
          s_d.ss = reg_wdata[15:0];
          s_d.st = analog_bus_pkg::SEQ_SW_SETUP;
        end else if (wr_conv) begin
          s_d.sel       = reg_wdata[4:0];
          s_d.res_valid = 1'b0;
          s_d.st        = analog_bus_pkg::SEQ_AD_SETUP;
        end
      end
      analog_bus_pkg::SEQ_SW_SETUP: begin
        if (s_q.cnt == 8'(`SETUP_CYC - 1)) begin
          s_d.cnt  = 8'h00;
          s_d.wrss = 1'b1;
          s_d.st   = analog_bus_pkg::SEQ_SW_STROBE;
        end else begin
          s_d.cnt = s_q.cnt + 8'h01;
        end
      end
      analog_bus_pkg::SEQ_SW_STROBE: begin
        if (s_q.cnt == 8'(`STROBE_CYC - 1)) begin
          s_d.cnt  = 8'h00;
          s_d.wrss = 1'b0;
          s_d.st   = analog_bus_pkg::SEQ_IDLE;
        end else begin
          s_d.cnt = s_q.cnt + 8'h01;
        end
      end
      analog_bus_pkg::SEQ_AD_SETUP: begin
        if (s_q.cnt == 8'(`SETUP_CYC - 1)) begin
          s_d.cnt   = 8'h00;
          s_d.adstr = 1'b1;
          s_d.st    = analog_bus_pkg::SEQ_AD_STROBE;
        end else begin
          s_d.cnt = s_q.cnt + 8'h01;
        end
      end
      analog_bus_pkg::SEQ_AD_STROBE: begin
        if (s_q.cnt == 8'(`STROBE_CYC - 1)) begin
          s_d.cnt   = 8'h00;
          s_d.adstr = 1'b0;
          s_d.st    = analog_bus_pkg::SEQ_AD_WAIT;
        end else begin
          s_d.cnt = s_q.cnt + 8'h01;
        end
      end
      analog_bus_pkg::SEQ_AD_WAIT: begin
        // Select stays put until the video board's value is taken
        if (s_q.cnt == 8'(`AD_SETTLE_CYC - 1)) begin
          s_d.cnt       = 8'h00;
          s_d.result    = converter_result_lines;
          s_d.res_valid = 1'b1;
          s_d.st        = analog_bus_pkg::SEQ_IDLE;
        end else begin
          s_d.cnt = s_q.cnt + 8'h01;
        end
      end
      default: begin
        s_d.st    = analog_bus_pkg::SEQ_IDLE;
        s_d.wrss  = 1'b0;
        s_d.adstr = 1'b0;
      end
    endcase

    // Read data for the cycle after the strobe
    s_d.rdata = 32'h0000_0000;
    if (reg_rd) begin
      if (hit(reg_addr, `REG_CTRL)) begin
        s_d.rdata = 32'(s_q.ctrl);
      end else if (hit(reg_addr, `REG_STATUS_OUT)) begin
        s_d.rdata = 32'(s_q.status);
      end else if (hit(reg_addr, `REG_SWITCH)) begin
        s_d.rdata = 32'(s_q.ss);
      end else if (hit(reg_addr, `REG_CONV)) begin
        s_d.rdata = 32'(s_q.sel);
      end else if (hit(reg_addr, `REG_RESULT)) begin
        s_d.rdata = 32'(s_q.result);
      end else if (hit(reg_addr, `REG_STATE)) begin
        s_d.rdata[`STATE_SEQ_BUSY]  = !seq_idle;
        s_d.rdata[`STATE_RES_VALID] = s_q.res_valid;
        s_d.rdata[`STATE_SER_BUSY]  = ser_busy || s_q.ser_load;
      end else if (hit(reg_addr, `REG_SERIAL)) begin
        s_d.rdata = 32'(s_q.ser_word);
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      s_q        <= '0;
      s_q.st     <= analog_bus_pkg::SEQ_IDLE;
      s_q.ctrl   <= `CTRL_RESET;
      s_q.status <= `STATUS_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // Serial link
  // ****************************************
  analog_serial_tx u_serial (
    .mclk       (mclk),
    .rst_sync_b (rst_sync_b),
    .load       (s_q.ser_load),
    .word       (s_q.ser_word),
    .busy       (ser_busy),
    .sck        (analog_serial_clock),
    .sdo        (analog_serial_data)
  );

  // ****************************************
  // Outputs
  // ****************************************
  assign reg_rdata              = s_q.rdata;
  assign switch_state_bus       = s_q.ss;
  assign switch_write_strobe    = s_q.wrss;
  assign converter_select       = s_q.sel;
  assign converter_read_strobe  = s_q.adstr;
  assign dac_clear_all_b        = !s_q.ctrl[`CTRL_DAC_CLR];
  assign driver_output_enable   = s_q.ctrl[`CTRL_DRV_EN];
  assign spare_latched_output   = s_q.ctrl[`CTRL_SPARE];
  assign general_status_outputs = s_q.status;
  assign system_bus_clock       = s_q.bclk;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_sync_b);

  ss_setup_a: assert property ($rose(switch_write_strobe) |-> $stable(switch_state_bus))
    else $error("switch bus changed as write strobe rose");
  ss_hold_a: assert property (switch_write_strobe |=> $stable(switch_state_bus))
    else $error("switch bus changed while write strobe high");
  ss_width_a: assert property ($rose(switch_write_strobe)
      |-> switch_write_strobe[*4] ##1 !switch_write_strobe)
    else $error("switch write strobe width wrong");
  sel_hold_a: assert property (
      converter_read_strobe || $fell(converter_read_strobe)
      |-> $stable(converter_select))
    else $error("converter select changed around read strobe");
  ad_sample_a: assert property ($fell(converter_read_strobe)
      |-> ##20 $rose(s_q.res_valid))
    else $error("converter result not taken after strobe");
  ad_order_a: assert property ($rose(s_q.res_valid)
      |-> s_q.result == $past(converter_result_lines))
    else $error("converter result not taken from lines");
  strobe_excl_a: assert property (!(switch_write_strobe && converter_read_strobe))
    else $error("both strobes high");
  dac_clear_a: assert property (wr_ctrl
      |=> dac_clear_all_b == !$past(reg_wdata[`CTRL_DAC_CLR]))
    else $error("dac clear does not follow control write");
  drv_enable_a: assert property (wr_ctrl
      |=> driver_output_enable == $past(reg_wdata[`CTRL_DRV_EN]))
    else $error("driver enable does not follow control write");
  spare_hold_a: assert property (!wr_ctrl |=> $stable(spare_latched_output))
    else $error("spare output moved without a write");
  status_write_a: assert property (wr_status
      |=> general_status_outputs == $past(reg_wdata[3:0]))
    else $error("status outputs do not follow write");
  bus_clock_a: assert property ($rose(system_bus_clock)
      |-> system_bus_clock[*2] ##1 !system_bus_clock)
    else $error("system clock half period wrong");
  sel_setup_a: assert property ($rose(converter_read_strobe)
      |-> $stable(converter_select))
    else $error("converter select changed as read strobe rose");
  ad_width_a: assert property ($rose(converter_read_strobe)
      |-> converter_read_strobe[*4] ##1 !converter_read_strobe)
    else $error("converter read strobe width wrong");
  ss_stable_a: assert property (!wr_switch |=> $stable(switch_state_bus))
    else $error("switch bus moved without a write");
  sel_stable_a: assert property (!wr_conv |=> $stable(converter_select))
    else $error("converter select moved without a write");
  res_hold_a: assert property (!$rose(s_q.res_valid) |-> $stable(s_q.result))
    else $error("converter result moved without a sample");
  dac_hold_a: assert property (!wr_ctrl |=> $stable(dac_clear_all_b))
    else $error("dac clear moved without a write");
  drv_hold_a: assert property (!wr_ctrl |=> $stable(driver_output_enable))
    else $error("driver enable moved without a write");
  status_hold_a: assert property (!wr_status |=> $stable(general_status_outputs))
    else $error("status outputs moved without a write");

  sw_write_c: cover property ($fell(switch_write_strobe));
  ad_read_c: cover property ($rose(s_q.res_valid));
  ser_send_c: cover property ($fell(ser_busy));
  dac_clear_c: cover property ($fell(dac_clear_all_b));
  drv_enable_c: cover property ($rose(driver_output_enable));

endmodule

// ### testbench/analog_boards_model.sv
`timescale 1ns/1ps

// ****************************************
// Analog and video boards seen from the backplane
// ****************************************
module analog_boards_model (
  input  wire logic        mclk,
  input  wire logic [15:0] switch_state_bus,
  input  wire logic        switch_write_strobe,
  input  wire logic [4:0]  converter_select,
  input  wire logic        converter_read_strobe,
  output logic      [17:0] converter_result_lines,
  input  wire logic        analog_serial_clock,
  input  wire logic        analog_serial_data,
  output logic      [15:0] sw_seen,
  output int               sw_cnt,
  output int               hold_err,
  output logic      [23:0] ser_seen,
  output int               ser_cnt
);
  logic       wr_prev;
  logic       rd_prev;
  logic [4:0] sel_q;
  int         hold;

  initial begin
    converter_result_lines = 18'h2AAAA;
    sw_seen = 16'h0;
    sw_cnt = 0;
    hold_err = 0;
    ser_seen = 24'h0;
    ser_cnt = 0;
    wr_prev = 1'b0;
    rd_prev = 1'b0;
    sel_q = 5'h0;
    hold = 0;
  end

  // Switch states are taken on the rising strobe
  always @(posedge switch_write_strobe) begin
    sw_seen <= switch_state_bus;
    sw_cnt <= sw_cnt + 1;
  end

  always @(posedge mclk) begin
    if (switch_write_strobe && wr_prev && switch_state_bus !== sw_seen) begin
      hold_err <= hold_err + 1;
    end
    if (converter_read_strobe && rd_prev && converter_select !== sel_q) begin
      hold_err <= hold_err + 1;
    end
    wr_prev <= switch_write_strobe;
    rd_prev <= converter_read_strobe;
    // Result driven for a while after the strobe, then the lines churn
    if (converter_read_strobe && !rd_prev) begin
      converter_result_lines <= {converter_select, ~converter_select, converter_select, 3'h5};
      sel_q <= converter_select;
      hold <= 40;
    end else if (hold > 0) begin
      hold <= hold - 1;
    end else begin
      converter_result_lines <= ~converter_result_lines;
    end
  end

  always @(posedge analog_serial_clock) begin
    ser_seen <= {ser_seen[22:0], analog_serial_data};
    ser_cnt <= ser_cnt + 1;
  end
endmodule

// ### testbench/timing_board_analog_bus_bench.sv
`timescale 1ns/1ps
`include "analog_bus_defs.svh"

module timing_board_analog_bus_bench;
  logic        mclk;
  logic        rst_b;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic [15:0] switch_state_bus;
  logic        switch_write_strobe;
  logic [4:0]  converter_select;
  logic        converter_read_strobe;
  logic [17:0] converter_result_lines;
  logic        dac_clear_all_b;
  logic        driver_output_enable;
  logic        system_bus_clock;
  logic        analog_serial_clock;
  logic        analog_serial_data;
  logic [3:0]  general_status_outputs;
  logic        spare_latched_output;
  logic [15:0] sw_seen;
  logic [23:0] ser_seen;
  int          sw_cnt;
  int          hold_err;
  int          ser_cnt;
  int          n_mismatch;
  int          num_checks;
  int          i;
  int          n;
  int          c;
  logic        prev;
  logic [31:0] v;
  logic [31:0] d;
  logic [4:0]  s;

  timing_board_analog_bus dut (
    .mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .switch_state_bus(switch_state_bus), .switch_write_strobe(switch_write_strobe),
    .converter_select(converter_select), .converter_read_strobe(converter_read_strobe),
    .converter_result_lines(converter_result_lines), .dac_clear_all_b(dac_clear_all_b),
    .driver_output_enable(driver_output_enable), .system_bus_clock(system_bus_clock),
    .analog_serial_clock(analog_serial_clock), .analog_serial_data(analog_serial_data),
    .general_status_outputs(general_status_outputs),
    .spare_latched_output(spare_latched_output)
  );

  analog_boards_model model (
    .mclk(mclk), .switch_state_bus(switch_state_bus),
    .switch_write_strobe(switch_write_strobe), .converter_select(converter_select),
    .converter_read_strobe(converter_read_strobe),
    .converter_result_lines(converter_result_lines),
    .analog_serial_clock(analog_serial_clock), .analog_serial_data(analog_serial_data),
    .sw_seen(sw_seen), .sw_cnt(sw_cnt), .hold_err(hold_err), .ser_seen(ser_seen),
    .ser_cnt(ser_cnt)
  );

  // ****************************************
  // Clock, bus tasks and checks
  // ****************************************
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  function automatic logic [31:0] conv_exp(input logic [4:0] sel);
    return {14'h0, sel, ~sel, sel, 3'h5};
  endfunction

  task automatic end_sim();
    if (n_mismatch == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] wd);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= wd;
    @(posedge mclk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] rv);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask

  task automatic wait_bit(input int b, input logic lvl);
    logic [31:0] sv;
    for (int k = 0; k < 600; k++) begin
      rd(`REG_STATE, sv);
      if (sv[b] === lvl) return;
    end
    n_mismatch++;
    end_sim();
  endtask

  initial begin
    #400000;
    n_mismatch++;
    end_sim();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    n_mismatch = 0;
    num_checks = 0;
    rst_b = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    void'($urandom(32'h9A5C));
    repeat (10) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    chk("dac_clear_b", 1, dac_clear_all_b);
    chk("drv_enable", 0, driver_output_enable);
    chk("serial_clk", 0, analog_serial_clock);
    n = 0;
    prev = system_bus_clock;
    repeat (40) begin
      @(posedge mclk);
      #1;
      if (system_bus_clock !== prev) n++;
      prev = system_bus_clock;
    end
    chk("bus_clk_edges", 20, n);
    for (i = 0; i < 8; i++) begin
      wr(`REG_CTRL, i);
      chk("dac_clear_b", !i[0], dac_clear_all_b);
      chk("drv_enable", i[1], driver_output_enable);
      chk("spare", i[2], spare_latched_output);
      rd(`REG_CTRL, d);
      chk("ctrl_read", i, d);
    end
    repeat (4) begin
      v = $urandom;
      wr(`REG_STATUS_OUT, v);
      chk("status", v[3:0], general_status_outputs);
      rd(`REG_STATUS_OUT, d);
      chk("status_read", v[3:0], d);
      chk("spare_hold", 1, spare_latched_output);
    end
    for (i = 7; i < 16; i++) begin
      wr(4'(i), $urandom);
      rd(4'(i), d);
      chk("unmapped", 0, d);
    end
    rd(`REG_CTRL, d);
    chk("ctrl_kept", 7, d);
    // Second write lands while busy and must be dropped
    repeat (3) begin
      v = $urandom;
      c = sw_cnt;
      wr(`REG_SWITCH, v[15:0]);
      wr(`REG_SWITCH, ~v[15:0]);
      wait_bit(`STATE_SEQ_BUSY, 1'b0);
      chk("switch_bus", v[15:0], switch_state_bus);
      chk("switch_taken", v[15:0], sw_seen);
      chk("switch_count", c + 1, sw_cnt);
      chk("switch_strobe", 0, switch_write_strobe);
      rd(`REG_SWITCH, d);
      chk("switch_read", v[15:0], d);
    end
    for (i = 0; i < 5; i++) begin
      s = (i == 0) ? 5'h00 : (i == 1) ? 5'h1F : 5'($urandom);
      wr(`REG_CONV, s);
      wr(`REG_CONV, ~s);
      wait_bit(`STATE_RES_VALID, 1'b1);
      chk("conv_select", s, converter_select);
      rd(`REG_CONV, d);
      chk("conv_read", s, d);
      rd(`REG_RESULT, d);
      chk("conv_result", conv_exp(s), d);
      rd(`REG_STATE, d);
      chk("result_valid", 0, d[`STATE_RES_VALID]);
    end
    chk("hold_faults", 0, hold_err);
    // Reset in the middle of a serial frame
    wr(`REG_SERIAL, $urandom);
    repeat (30) @(posedge mclk);
    rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    chk("reset_dac_b", 1, dac_clear_all_b);
    chk("reset_drv", 0, driver_output_enable);
    chk("reset_spare", 0, spare_latched_output);
    chk("reset_status", 0, general_status_outputs);
    chk("reset_switch", 0, switch_state_bus);
    chk("reset_sck", 0, analog_serial_clock);
    chk("reset_sdo", 0, analog_serial_data);
    repeat (2) begin
      v = $urandom;
      c = ser_cnt;
      wr(`REG_SERIAL, v[23:0]);
      wr(`REG_SERIAL, ~v[23:0]);
      wait_bit(`STATE_SER_BUSY, 1'b0);
      chk("serial_word", v[23:0], ser_seen);
      chk("serial_bits", c + `SER_BITS, ser_cnt);
      chk("serial_idle", 0, analog_serial_clock);
      rd(`REG_SERIAL, d);
      chk("serial_read", v[23:0], d);
    end
    end_sim();
  end
endmodule
